// file: hw/sracc_pkg.sv
// Purpose: Shared constants and types for the serial register access block.
// Assumes: 16-bit command words, 6-bit register address, 6-bit word count.
// Notes:   Offsets are register indices on the serial command channel.
package sracc_pkg;

  localparam int          CORE_KHZ     = 50000;
  localparam int          WDT_UNIT_MS  = 10;
  localparam int          TMO_UNIT_US  = 500;

  localparam logic [5:0]  ADR_ID       = 6'h00;
  localparam logic [5:0]  ADR_HOSTCTL  = 6'h01;
  localparam logic [5:0]  ADR_DIAG     = 6'h06;
  localparam logic [5:0]  ADR_STATUS   = 6'h07;
  localparam logic [5:0]  ADR_INTERFACE_STATUS     = 6'h08;
  localparam logic [5:0]  ADR_TXQST    = 6'h09;
  localparam logic [5:0]  ADR_RXQST    = 6'h0a;

  localparam int          RW_NUM       = 6;
  localparam logic [15:0] RST_HOSTCTL  = 16'h00a0;
  localparam logic [15:0] RST_CHAIN    = 16'h0000;
  localparam logic [15:0] RST_TXLVL    = 16'h01ff;
  localparam logic [15:0] RST_RXLVL    = 16'h00ff;
  localparam logic [15:0] RST_DEVCTL   = 16'h0000;
  localparam logic [15:0] RST_DIAG     = 16'h0000;
  localparam logic [15:0] RW_RST [RW_NUM] = '{RST_HOSTCTL, RST_CHAIN, RST_TXLVL,
                                              RST_RXLVL, RST_DEVCTL, RST_DIAG};

  localparam int          WDT_LSB      = 12;
  localparam int          TMO_LSB      = 4;
  localparam int          POLY_BIT     = 2;
  localparam int          TRI_BIT      = 1;
  localparam int          ACKOFF_BIT   = 0;
  localparam int          MASK_SPICRC  = 0;

  localparam int          ST_POR       = 0;
  localparam int          ST_ERR       = 1;
  localparam int          ST_SPICRC    = 2;
  localparam int          ST_SRSTF     = 3;
  localparam int          ST_SAFE      = 4;

  localparam logic [3:0]  OP_RD        = 4'hd;
  localparam logic [3:0]  OP_WR        = 4'hb;
  localparam logic [15:0] CMD_SRST     = 16'he1e1;

  localparam logic [15:0] CRC_POLY     = 16'h1021;
  localparam logic [15:0] INIT_FALSE   = 16'hffff;
  localparam logic [15:0] INIT_XMODEM  = 16'h0000;
  localparam logic [15:0] SRST_FALSE   = 16'hd383;
  localparam logic [15:0] SRST_XMODEM  = 16'hce8c;

  // Idle timeout per code, in 500 us units; zero means disabled.
  localparam logic [8:0]  TMO_UNITS [16] = '{9'h000, 9'h001, 9'h002, 9'h004,
                                             9'h006, 9'h008, 9'h00a, 9'h014,
                                             9'h01e, 9'h028, 9'h03c, 9'h050,
                                             9'h064, 9'h0aa, 9'h0f0, 9'h190};

  typedef enum logic [4:0] {
    K_NONE = 5'h01,
    K_RD   = 5'h02,
    K_WR   = 5'h04,
    K_SRST = 5'h08,
    K_SKIP = 5'h10
  } sracc_kind_t;

  typedef struct packed {
    logic        wr;
    logic [5:0]  addr;
    logic [15:0] data;
  } sracc_req_t;

  typedef struct packed {
    sracc_kind_t kind;
    logic        crc_ok;
  } sracc_evt_t;

  typedef struct packed {
    logic resync;
    logic rxq_flush;
    logic crc_clear;
  } sracc_srst_t;

  typedef struct packed {
    logic [15:0] chain;
    logic [15:0] txlvl;
    logic [15:0] rxlvl;
    logic [15:0] devctl;
  } sracc_cfg_t;

  // One 16-bit word through polynomial 0x1021, MSB first, no final XOR.
  function automatic logic [15:0] sracc_crc16(input logic [15:0] crc,
                                              input logic [15:0] data);
    logic [15:0] c;
    c = crc;
    for (int i = 15; i >= 0; i--) begin
      if (c[15] ^ data[i]) begin
        c = {c[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction : sracc_crc16

endpackage : sracc_pkg

// file: hw/sracc_top.sv
// Purpose: Serial command interpreter for register read, register write and soft reset.
// Assumes: Serial mode 0; chip select low frames a command; link clock stops between frames.
// Notes:   The link side runs on i_sclk; core side on i_core_clk.
//
// Summary of operation
// - Read returns words and CRC despite CRC fail.
// - Read command holds first address; words consecutive.
// - Read CRC mismatch sets flag, alarm unless masked.
// - Soft reset restores defaults and resyncs link.
// - Soft reset needs good CRC, idle link.
// - Soft reset CRC is 0xd383 or 0xce8c.
// - Soft reset clears flags, sets power-on, error.
// - Soft reset makes receive queue data unreadable.
// - Soft reset discards stored link CRC values.
// - Valid soft reset leaves safe state.
// - Rejected soft reset sets failure status bit.
// - Inactivity watchdog 40/20/10 ms or off.
// - Clock idle timeout resets serial receiver.
// - Control bit two selects CRC variant.
// - Control bit one tristates serial output.
// - Control bit zero disables status auto-reply.
`timescale 1ns/100ps
`default_nettype none
module sracc_top #(
  parameter int          WDT_UNIT_CYC = sracc_pkg::WDT_UNIT_MS * sracc_pkg::CORE_KHZ,
  parameter int          TMO_UNIT_CYC = sracc_pkg::TMO_UNIT_US * sracc_pkg::CORE_KHZ / 1000,
  parameter logic [15:0] CHIP_ID      = 16'h5a01  // Arbitrary value.
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire logic              i_sclk,
  input  wire logic              i_cs_n,
  input  wire logic              i_sdi,
  input  wire logic              i_link_busy,
  input  wire logic [15:0]       i_iface_status,
  input  wire logic [15:0]       i_txq_status,
  input  wire logic [15:0]       i_rxq_status,
  output var  logic              o_sdo,
  output var  logic              o_sdo_oe_n,
  output var  logic              o_alarm_o,
  output var  logic              o_alarm_oe_n,
  output var  logic              o_safe_state,
  output var  sracc_pkg::sracc_srst_t o_srst,
  output var  sracc_pkg::sracc_cfg_t  o_cfg
);
  import sracc_pkg::*;

  // Core-side state read by the link side.
  logic              abort_r;
  logic [15:0]       rd_data_r;
  logic [15:0]       rw_r [RW_NUM];

  // Link-side state.
  logic              spi_rst;
  logic [3:0]        bit_cnt_r, bit_cnt_nxt;
  logic [6:0]        idx_r, idx_nxt;
  logic [15:0]       rx_sr_r, rx_sr_nxt;
  logic [15:0]       cmd_r, cmd_nxt;
  sracc_kind_t       kind_r, kind_nxt;
  logic [15:0]       rx_crc_r, rx_crc_nxt;
  logic [15:0]       tx_sr_r, tx_sr_nxt;
  logic [15:0]       tx_crc_r, tx_crc_nxt;
  sracc_req_t        req_r, req_nxt;
  logic              req_tgl_r, req_tgl_nxt;
  sracc_evt_t        evt_r, evt_nxt;
  logic              evt_tgl_r, evt_tgl_nxt;
  logic              act_r;
  logic [1:0]        poly_s, ackoff_s;
  logic              ld_v;
  logic              ld_first;
  logic [15:0]       ld_w;

  wire  [15:0]       hostctl   = rw_r[0];
  wire  [15:0]       rx_word   = {rx_sr_r[14:0], i_sdi};
  wire               boundary  = (bit_cnt_r == 4'hf);
  wire  [6:0]        word_cnt  = {1'b0, cmd_r[5:0]} + 7'h01;
  wire  [6:0]        cnt_p1    = word_cnt + 7'h01;
  wire  [6:0]        cnt_p2    = word_cnt + 7'h02;
  wire  [15:0]       crc_init  = poly_s[1] ? INIT_XMODEM : INIT_FALSE;
  wire  [15:0]       srst_crc  = poly_s[1] ? SRST_XMODEM : SRST_FALSE;
  wire               ackoff    = ackoff_s[1];
  wire  [5:0]        rd_next   = cmd_r[11:6] + idx_r[5:0];
  wire  [5:0]        wr_addr   = cmd_r[11:6] + idx_r[5:0] - 6'h01;

  // Frame end or a clock-idle abort clears the whole link side.
  assign spi_rst = i_rst | i_cs_n | abort_r;

  always_comb begin
    bit_cnt_nxt = bit_cnt_r + 4'h1;
    rx_sr_nxt   = rx_word;
    idx_nxt     = idx_r;
    cmd_nxt     = cmd_r;
    kind_nxt    = kind_r;
    rx_crc_nxt  = rx_crc_r;
    req_nxt     = req_r;
    req_tgl_nxt = req_tgl_r;
    evt_nxt     = evt_r;
    evt_tgl_nxt = evt_tgl_r;
    tx_sr_nxt   = {tx_sr_r[14:0], 1'b1};
    tx_crc_nxt  = tx_crc_r;
    ld_v        = 1'b0;
    ld_first    = 1'b0;
    ld_w        = 16'hffff;
    if (boundary) begin
      if (idx_r != 7'h7f) begin
        idx_nxt = idx_r + 7'h01;
      end
      rx_crc_nxt = sracc_crc16((idx_r == 7'h00) ? crc_init : rx_crc_r, rx_word);
      case (kind_r)
        K_NONE: begin
          cmd_nxt = rx_word;
          if (rx_word == CMD_SRST) begin
            kind_nxt    = K_SRST;
            req_nxt     = '{wr: 1'b0, addr: ADR_STATUS, data: 16'h0000};
            req_tgl_nxt = ~req_tgl_r;
          end else if (rx_word[15:12] == OP_RD) begin
            kind_nxt    = K_RD;
            req_nxt     = '{wr: 1'b0, addr: rx_word[11:6], data: 16'h0000};
            req_tgl_nxt = ~req_tgl_r;
          end else if (rx_word[15:12] == OP_WR) begin
            kind_nxt = K_WR;
          end else begin
            kind_nxt = K_SKIP;
          end
        end
        K_RD: begin
          if (idx_r == 7'h01) begin
            evt_nxt     = '{kind: K_RD, crc_ok: (rx_word == rx_crc_r)};
            evt_tgl_nxt = ~evt_tgl_r;
          end
          // Words go out whatever the command CRC check said.
          if (idx_r >= 7'h01 && idx_r <= word_cnt) begin
            ld_v     = 1'b1;
            ld_w     = rd_data_r;
            ld_first = (idx_r == 7'h01);
          end
          if (idx_r >= 7'h01 && idx_r < word_cnt) begin
            req_nxt     = '{wr: 1'b0, addr: rd_next, data: 16'h0000};
            req_tgl_nxt = ~req_tgl_r;
          end
          if (idx_r == cnt_p1) begin
            ld_v = 1'b1;
            ld_w = tx_crc_r;
          end
        end
        K_WR: begin
          if (idx_r >= 7'h01 && idx_r <= word_cnt) begin
            req_nxt     = '{wr: 1'b1, addr: wr_addr, data: rx_word};
            req_tgl_nxt = ~req_tgl_r;
          end
          if (idx_r == cnt_p1) begin
            evt_nxt     = '{kind: K_WR, crc_ok: (rx_word == rx_crc_r)};
            evt_tgl_nxt = ~evt_tgl_r;
            ld_v        = ~ackoff;
            ld_w        = rd_data_r;
            ld_first    = 1'b1;
          end
          if (idx_r == cnt_p2) begin
            ld_v = ~ackoff;
            ld_w = tx_crc_r;
          end
        end
        K_SRST: begin
          if (idx_r == 7'h01) begin
            evt_nxt     = '{kind: K_SRST, crc_ok: (rx_word == srst_crc)};
            evt_tgl_nxt = ~evt_tgl_r;
            ld_v        = ~ackoff;
            ld_w        = rd_data_r;
            ld_first    = 1'b1;
          end
          if (idx_r == 7'h02) begin
            ld_v = ~ackoff;
            ld_w = tx_crc_r;
          end
        end
        default: begin
        end
      endcase
      if (ld_v) begin
        tx_sr_nxt  = ld_w;
        tx_crc_nxt = sracc_crc16(ld_first ? crc_init : tx_crc_r, ld_w);
      end
    end
  end

  always_ff @(posedge i_sclk or posedge spi_rst) begin
    if (spi_rst) begin
      bit_cnt_r <= 4'h0;
      idx_r     <= 7'h00;
      rx_sr_r   <= 16'h0000;
      cmd_r     <= 16'h0000;
      kind_r    <= K_NONE;
      rx_crc_r  <= 16'h0000;
      tx_sr_r   <= 16'hffff;
      tx_crc_r  <= 16'h0000;
      req_r     <= '0;
      req_tgl_r <= 1'b0;
      evt_r     <= '{kind: K_NONE, crc_ok: 1'b0};
      evt_tgl_r <= 1'b0;
      act_r     <= 1'b0;
      poly_s    <= 2'h0;
      ackoff_s  <= 2'h0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      idx_r     <= idx_nxt;
      rx_sr_r   <= rx_sr_nxt;
      cmd_r     <= cmd_nxt;
      kind_r    <= kind_nxt;
      rx_crc_r  <= rx_crc_nxt;
      tx_sr_r   <= tx_sr_nxt;
      tx_crc_r  <= tx_crc_nxt;
      req_r     <= req_nxt;
      req_tgl_r <= req_tgl_nxt;
      evt_r     <= evt_nxt;
      evt_tgl_r <= evt_tgl_nxt;
      act_r     <= ~act_r;
      poly_s    <= {poly_s[0], hostctl[POLY_BIT]};
      ackoff_s  <= {ackoff_s[0], hostctl[ACKOFF_BIT]};
    end
  end

  // Output changes on the falling edge so the host samples a settled bit.
  always_ff @(negedge i_sclk or posedge spi_rst) begin
    if (spi_rst) begin
      o_sdo <= 1'b1;
    end else begin
      o_sdo <= tx_sr_r[15];
    end
  end

  // Core side.
  logic [2:0]        req_s, evt_s, act_s;
  logic [1:0]        cs_s;
  logic              por_r, err_r, spicrc_r, srstf_r, safe_r;
  logic [19:0]       wdt_cyc_r;
  logic [2:0]        wdt_units_r;
  logic [14:0]       tmo_cyc_r;
  logic [8:0]        tmo_units_r;
  logic [15:0]       status_w;

  wire               req_edge  = req_s[1] ^ req_s[2];
  wire               evt_edge  = evt_s[1] ^ evt_s[2];
  wire               act_edge  = act_s[1] ^ act_s[2];
  wire               cs_low    = ~cs_s[1];
  wire               is_rw     = (evt_r.kind == K_RD) | (evt_r.kind == K_WR);
  wire               is_srst   = evt_edge & (evt_r.kind == K_SRST);
  wire               crc_bad   = evt_edge & is_rw & ~evt_r.crc_ok;
  wire               srst_go   = is_srst & evt_r.crc_ok & ~i_link_busy;
  wire               srst_bad  = is_srst & ~srst_go;
  wire               st_read   = req_edge & ~req_r.wr & (req_r.addr == ADR_STATUS);
  wire  [1:0]        wdt_sel   = hostctl[WDT_LSB +: 2];
  wire  [2:0]        wdt_limit = 3'h4 >> wdt_sel;
  wire               wdt_on    = (wdt_sel != 2'h3);
  wire               wdt_tick  = (wdt_cyc_r == 20'(WDT_UNIT_CYC - 1));
  wire               wdt_fire  = wdt_on & wdt_tick & (wdt_units_r == wdt_limit - 3'h1);
  wire  [3:0]        tmo_code  = hostctl[TMO_LSB +: 4];
  wire               tmo_tick  = (tmo_cyc_r == 15'(TMO_UNIT_CYC - 1));
  wire               tmo_run   = cs_low & ~act_edge & (tmo_code != 4'h0);
  wire               tmo_fire  = tmo_run & (tmo_units_r == TMO_UNITS[tmo_code]);
  wire               rw_hit    = (req_r.addr >= ADR_HOSTCTL) & (req_r.addr <= ADR_DIAG);
  wire  [2:0]        rw_idx    = 3'(req_r.addr - ADR_HOSTCTL);
  wire  [15:0]       rd_mux    = (req_r.addr == ADR_ID)     ? CHIP_ID :
                                 rw_hit                     ? rw_r[rw_idx] :
                                 (req_r.addr == ADR_STATUS) ? status_w :
                                 (req_r.addr == ADR_INTERFACE_STATUS)   ? i_iface_status :
                                 (req_r.addr == ADR_TXQST)  ? i_txq_status :
                                 (req_r.addr == ADR_RXQST)  ? i_rxq_status : 16'h0000;

  always_comb begin
    status_w            = 16'h0000;
    status_w[ST_POR]    = por_r;
    status_w[ST_ERR]    = err_r;
    status_w[ST_SPICRC] = spicrc_r;
    status_w[ST_SRSTF]  = srstf_r;
    status_w[ST_SAFE]   = safe_r;
  end

  // Request words are held for a whole 16-bit slot, so one toggle crossing suffices.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      req_s <= 3'h0;
      evt_s <= 3'h0;
      act_s <= 3'h0;
      cs_s  <= 2'h3;
    end else begin
      req_s <= {req_s[1:0], req_tgl_r};
      evt_s <= {evt_s[1:0], evt_tgl_r};
      act_s <= {act_s[1:0], act_r};
      cs_s  <= {cs_s[0], i_cs_n};
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_data_r <= 16'hffff;
    end else if (req_edge) begin
      rd_data_r <= req_r.wr ? status_w : rd_mux;
    end
  end

  // Unmapped and read-only addresses swallow writes.
  for (genvar gi = 0; gi < RW_NUM; gi++) begin : g_rw
    wire wr_hit = req_edge & req_r.wr & (req_r.addr == ADR_HOSTCTL + 6'(gi));
    always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
        rw_r[gi] <= RW_RST[gi];
      end else if (srst_go) begin
        rw_r[gi] <= RW_RST[gi];
      end else if (wr_hit) begin
        rw_r[gi] <= req_r.data;
      end
    end
  end

  // Hardware sets win over every clear in the same cycle.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      por_r    <= 1'b1;
      err_r    <= 1'b1;
      spicrc_r <= 1'b0;
      srstf_r  <= 1'b0;
      safe_r   <= 1'b0;
    end else begin
      por_r    <= srst_go | (por_r & ~st_read);
      err_r    <= srst_go | (err_r & ~st_read);
      spicrc_r <= crc_bad | (spicrc_r & ~srst_go);
      srstf_r  <= srst_bad | (srstf_r & ~srst_go);
      safe_r   <= wdt_fire | (safe_r & ~srst_go);
    end
  end

  // Each read, write or soft reset command resets the inactivity watchdog; unknown commands do not.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wdt_cyc_r   <= 20'h00000;
      wdt_units_r <= 3'h0;
    end else if (evt_edge | ~wdt_on) begin
      wdt_cyc_r   <= 20'h00000;
      wdt_units_r <= 3'h0;
    end else if (wdt_fire) begin
      wdt_cyc_r   <= 20'h00000;
    end else if (wdt_tick) begin
      wdt_cyc_r   <= 20'h00000;
      wdt_units_r <= wdt_units_r + 3'h1;
    end else begin
      wdt_cyc_r   <= wdt_cyc_r + 20'h00001;
    end
  end

  // The idle timer runs only inside a frame; the link clock may stop outside one.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tmo_cyc_r   <= 15'h0000;
      tmo_units_r <= 9'h000;
      abort_r     <= 1'b0;
    end else begin
      if (!tmo_run || tmo_fire || tmo_tick) begin
        tmo_cyc_r <= 15'h0000;
      end else begin
        tmo_cyc_r <= tmo_cyc_r + 15'h0001;
      end
      if (!tmo_run) begin
        tmo_units_r <= 9'h000;
      end else if (tmo_tick && !tmo_fire) begin
        tmo_units_r <= tmo_units_r + 9'h001;
      end
      if (tmo_fire) begin
        abort_r <= 1'b1;
      end else if (!cs_low) begin
        abort_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sdo_oe_n   <= 1'b1;
      o_alarm_o    <= 1'b0;
      o_alarm_oe_n <= 1'b1;
      o_safe_state <= 1'b0;
      o_srst       <= '0;
    end else begin
      o_sdo_oe_n   <= ~(cs_low & ~hostctl[TRI_BIT]);
      o_alarm_o    <= 1'b0;
      o_alarm_oe_n <= ~(spicrc_r & ~rw_r[5][MASK_SPICRC]);
      o_safe_state <= safe_r;
      o_srst       <= '{resync: srst_go, rxq_flush: srst_go, crc_clear: srst_go};
    end
  end

  assign o_cfg = '{chain: rw_r[1], txlvl: rw_r[2], rxlvl: rw_r[3], devctl: rw_r[4]};

endmodule : sracc_top
`default_nettype wire

// file: verif/sracc_chk.sv
// Purpose: Port-level checks of the serial register access block.
// Assumes: One core clock domain samples every watched port.
// Notes:   Bound into sracc_top below the module.
`timescale 1ns/100ps
`default_nettype none
module sracc_chk (
  input wire logic                   i_core_clk,
  input wire logic                   i_rst,
  input wire logic                   i_cs_n,
  input wire logic                   i_link_busy,
  input wire logic                   o_sdo,
  input wire logic                   o_sdo_oe_n,
  input wire logic                   o_alarm_o,
  input wire logic                   o_safe_state,
  input wire sracc_pkg::sracc_srst_t o_srst,
  input wire sracc_pkg::sracc_cfg_t  o_cfg
);
  import sracc_pkg::*;
  localparam logic [63:0] DFLT = {RST_CHAIN, RST_TXLVL, RST_RXLVL, RST_DEVCTL};
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence srst_go;
    o_srst.resync;
  endsequence
  sequence srst_end;
    ##1 !o_srst.resync;
  endsequence
  a_srst_one_pulse: assert property (srst_go |-> srst_end)
    else $error("soft reset pulse longer than one cycle");
  a_srst_all_three: assert property (o_srst.resync == o_srst.rxq_flush
    && o_srst.resync == o_srst.crc_clear) else $error("soft reset pulses differ");
  a_srst_link_idle: assert property (srst_go |-> !$past(i_link_busy))
    else $error("soft reset while link busy");
  a_srst_cfg_dflt: assert property (srst_go |-> ##[0:1] (o_cfg == DFLT))
    else $error("registers not at default after soft reset");
  a_srst_safe_off: assert property (srst_go |-> ##[0:1] !o_safe_state)
    else $error("safe state kept after soft reset");
  a_idle_sdo_high: assert property (i_cs_n |-> o_sdo)
    else $error("serial output not high outside frame");
  a_oe_cs_rise: assert property ($rose(i_cs_n) |-> ##[1:4] o_sdo_oe_n)
    else $error("serial output still driven after frame");
  a_alarm_drain: assert property (!o_alarm_o)
    else $error("alarm line driven high");
endmodule : sracc_chk
bind sracc_top sracc_chk i_chk (.i_core_clk, .i_rst, .i_cs_n, .i_link_busy, .o_sdo,
  .o_sdo_oe_n, .o_alarm_o, .o_safe_state, .o_srst, .o_cfg);
`default_nettype wire

// file: verif/sracc_host.sv
// Purpose: Serial host model, mode 0, clock still between frames.
// Assumes: Bit period 125 ns; caller fills tx before a frame.
// Notes:   Reply words are captured on rising clock edges.
`timescale 1ns/100ps
`default_nettype none
module sracc_host (
  output var logic o_sclk,
  output var logic o_cs_n,
  output var logic o_sdi,
  input wire logic i_sdo,
  input wire logic i_sdo_oe_n
);
  logic [15:0] tx [4];
  logic [15:0] rx [14];
  logic        oe_seen;
  initial begin
    o_sclk = 0;
    o_cs_n = 1;
    o_sdi = 0;
  end
  task automatic frame(input int nt, input int nr, input int gap);
    o_cs_n = 0;
    #(200 + gap);
    for (int b = 0; b < 16 * (nt + nr); b++) begin
      // Filler bits flip so a stuck input cannot pass for data.
      o_sdi = (b < 16 * nt) ? tx[b / 16][15 - b % 16] : ~o_sdi;
      #62.5 o_sclk = 1;
      if (b >= 16 * nt) rx[b / 16 - nt][15 - b % 16] = i_sdo;
      if (b == 8) oe_seen = i_sdo_oe_n;
      #62.5 o_sclk = 0;
    end
    #200 o_cs_n = 1;
    #500;
  endtask : frame
endmodule : sracc_host
`default_nettype wire

// file: verif/spi_register_access_softreset_test.sv
// Purpose: Directed test of register read, write and soft reset commands.
// Assumes: Shortened watchdog and idle timeout units for simulation.
// Notes:   Expected check words are computed here, apart from the design.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, ac) begin checked++; if ((ac) !== (ex)) begin n_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, ac); end end
module spi_register_access_softreset_test;
  import sracc_pkg::*;
  localparam logic [15:0] ID = 16'h3c5a;  // Arbitrary value.
  logic        i_core_clk, i_rst, i_link_busy, tgl;
  logic        sclk, cs_n, sdi, sdo, sdo_oe_n, alarm_oe_n, safe;
  wire logic   sdo_w;
  sracc_srst_t srst_p;
  sracc_cfg_t  cfg;
  logic [15:0] e [14];
  logic [15:0] ini;
  int          n_errors, checked, n_srst;
  // A released output floats, so the host sees a changing pattern.
  assign sdo_w = sdo_oe_n ? tgl : sdo;
  sracc_top #(.WDT_UNIT_CYC(2000), .TMO_UNIT_CYC(40), .CHIP_ID(ID)) i_dut (
    .i_core_clk, .i_rst, .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi), .i_link_busy,
    .i_iface_status(16'h1111), .i_txq_status(16'h2222), .i_rxq_status(16'h3333),
    .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .o_alarm_o(), .o_alarm_oe_n(alarm_oe_n),
    .o_safe_state(safe), .o_srst(srst_p), .o_cfg(cfg));
  sracc_host i_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo_w),
    .i_sdo_oe_n(sdo_oe_n));
  initial begin
    i_core_clk = 0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  always @(negedge i_core_clk) tgl <= ~tgl;
  always @(posedge i_core_clk) if (srst_p.resync === 1'b1) n_srst++;
  function automatic logic [15:0] crc(input logic [15:0] c, input logic [15:0] d);
    for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction : crc
  task automatic fin(input int n);
    e[n] = ini;
    for (int i = 0; i < n; i++) e[n] = crc(e[n], e[i]);
  endtask : fin
  task automatic dflt();
    e[0] = ID;
    for (int i = 0; i < RW_NUM; i++) e[i + 1] = RW_RST[i];
    e[7] = 16'h0003;
  endtask : dflt
  task automatic rd(input logic [5:0] a, input int n, input logic bad, input int gap);
    i_host.tx[0] = {4'hd, a, 6'(n - 1)};
    i_host.tx[1] = crc(ini, i_host.tx[0]) ^ {15'h0, bad};
    i_host.frame(2, n + 1, gap);
    for (int i = 0; i <= n; i++) `CHK("read word", e[i], i_host.rx[i])
  endtask : rd
  task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic ck,
                    input logic [15:0] st);
    i_host.tx[0] = {4'hb, a, 6'h00};
    i_host.tx[1] = d;
    i_host.tx[2] = crc(crc(ini, i_host.tx[0]), d);
    i_host.frame(3, 2, 0);
    if (ck) `CHK("write reply", st, i_host.rx[0])
  endtask : wr
  task automatic srst(input logic [15:0] c);
    i_host.tx[0] = CMD_SRST;
    i_host.tx[1] = c;
    // No driver chain is modelled here, so no end bytes follow the reset.
    i_host.frame(2, 2, 0);
  endtask : srst
  task automatic complete_run();
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  initial begin
    i_rst = 1;
    i_link_busy = 0;
    tgl = 0;
    ini = INIT_FALSE;
    repeat (2) @(negedge i_core_clk);
    i_rst = 0;
    repeat (5) @(negedge i_core_clk);
    dflt();
    e[8] = 16'h1111;
    e[9] = 16'h2222;
    e[10] = 16'h3333;
    e[11] = 16'h0000;
    fin(12);
    rd(6'h00, 12, 0, 0);
    wr(6'h01, 16'h30a4, 1, 16'h0000);
    ini = INIT_XMODEM;
    e[0] = 16'h30a4;
    fin(1);
    rd(6'h01, 1, 0, 0);
    e[0] = 16'h1111;
    fin(1);
    rd(6'h08, 1, 1, 0);
    `CHK("alarm", 1'b0, alarm_oe_n)
    e[0] = 16'h0004;
    fin(1);
    rd(6'h07, 1, 0, 0);
    wr(6'h06, 16'h0001, 0, 16'h0000);
    `CHK("alarm masked", 1'b1, alarm_oe_n)
    srst(16'h1234);
    @(negedge i_core_clk) i_link_busy = 1;
    srst(SRST_XMODEM);
    @(negedge i_core_clk) i_link_busy = 0;
    `CHK("resets", 0, n_srst)
    e[0] = 16'h000c;
    fin(1);
    rd(6'h07, 1, 0, 0);
    wr(6'h01, 16'h20a4, 0, 16'h0000);
    repeat (1500) @(negedge i_core_clk);
    `CHK("safe early", 1'b0, safe)
    repeat (1000) @(negedge i_core_clk);
    `CHK("safe", 1'b1, safe)
    srst(SRST_XMODEM);
    ini = INIT_FALSE;
    `CHK("safe left", 1'b0, safe)
    dflt();
    fin(8);
    rd(6'h00, 8, 0, 0);
    srst(SRST_FALSE);
    `CHK("resets", 2, n_srst)
    // A write lands before its own reply, so the new reply setting already governs it.
    wr(6'h01, 16'h00a1, 1, 16'hffff);
    `CHK("output driven", 1'b0, i_host.oe_seen)
    wr(6'h01, 16'h00a0, 1, 16'h0003);
    wr(6'h01, 16'h00a2, 0, 16'h0000);
    wr(6'h01, 16'h00a0, 0, 16'h0000);
    `CHK("output released", 1'b1, i_host.oe_seen)
    e[0] = 16'hffff;
    e[1] = 16'hffff;
    rd(6'h00, 1, 0, 60000);
    e[0] = ID;
    fin(1);
    rd(6'h00, 1, 0, 0);
    complete_run();
  end
  initial begin
    #1500000;
    n_errors++;
    complete_run();
  end
endmodule : spi_register_access_softreset_test
`default_nettype wire
